/* File: hdl/acc_control.sv */
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
// Operation
// - writing one to start requests exactly one conversion; start reads zero
// - a start during a running conversion waits until that one completes
// - a conversion is 2^count elementary conversions with input chopped between them
// - each elementary conversion lasts 2^(3+ratio field) samples, 8 to 1024
// - setting repeat starts a conversion and restarts after each end while set
// - every completed repeat conversion updates the result and pulses a trigger
// - the test bit is held at zero and writes to it are ignored
// - both bias fields select 0.25 times one plus field of nominal current
// - enable bit 0 runs the modulator; bits 1 to 3 enable stages, else bypass
// - sampling field picks rc/4, rc/8, rc/32 or about 8 kHz
// - stage one gain bit selects gain 1 or 10
// - stage two gain codes give 1, 2, 5 and 10
// - stage three gain is field value times one twelfth
// - stage two shift is sign-magnitude, -1 to +1 in 0.2 steps
// - stage three shift is sign-magnitude, -5.25 to +5.25 in twelfths
// - busy reads one during a conversion, raised at its actual start
// - busy may lag a start or repeat write by one sampling period
// - restore defaults resets configuration and restarts a conversion at once
// - input select: bit 4 mode, bit 3 polarity, bits 2 to 0 channel
// - reference select picks pins 1/0 when clear and pins 3/2 when set
// - result is 16-bit two's complement over two 8-bit read-only registers
// - single-shot and repeat conversions run identically, only starting differs
module acc_control #(
  parameter int RESULT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic modulator_bit,
  output logic modulator_on,
  output logic [2:0] stage_enable,
  output logic [1:0] converter_bias_sel,
  output logic [1:0] amplifier_bias_sel,
  output logic stage_one_gain,
  output logic [1:0] stage_two_gain,
  output logic [3:0] stage_two_shift,
  output logic [6:0] stage_three_gain,
  output logic [6:0] stage_three_shift,
  output logic [4:0] input_select,
  output logic reference_select,
  output logic sample_strobe,
  output logic chop_phase,
  output logic conversion_done,
  output logic [RESULT_W-1:0] result
);
  import acc_pkg::*;

  // the result byte registers serve exactly sixteen bits
  if (RESULT_W != 16) begin : g_bad_width
    $error("acc_control: result width must be 16");
  end

  // ==========================================================================
  // apb decode
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  assign addr_ok = (paddr == ADDR_RESULT_LOW) || (paddr == ADDR_RESULT_HIGH)
      || (paddr == ADDR_CONV_CTRL) || (paddr == ADDR_BIAS_EN)
      || (paddr == ADDR_SAMP_STAGE2) || (paddr == ADDR_GAIN13)
      || (paddr == ADDR_SHIFT3) || (paddr == ADDR_STAT_MUX);
  assign wr_acc = clk_en && psel && penable && pwrite && !pready;
  assign rd_acc = clk_en && psel && penable && !pwrite && !pready;

  logic def_wr;
  logic start_wr;
  assign def_wr = wr_acc && (paddr == ADDR_STAT_MUX) && pwdata[SM_DEF_BIT];
  assign start_wr = wr_acc && (paddr == ADDR_CONV_CTRL) && pwdata[CC_START_BIT];

  // ==========================================================================
  // configuration registers
  logic [1:0] elem_sel_r;
  logic [2:0] osr_sel_r;
  logic repeat_r;
  logic [7:0] bias_en_r;
  logic [7:0] samp_stage2_r;
  logic [7:0] gain13_r;
  logic [6:0] shift3_r;
  logic [5:0] mux_r;
  // a restore outranks the write that carries it

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      elem_sel_r <= ELEM_DEFAULT;
      osr_sel_r <= OSR_DEFAULT;
      repeat_r <= 1'b0;
      bias_en_r <= BIAS_EN_DEFAULT;
      samp_stage2_r <= SAMP_STAGE2_DEFAULT;
      gain13_r <= GAIN13_DEFAULT;
      shift3_r <= SHIFT3_DEFAULT;
      mux_r <= MUX_DEFAULT;
    end else if (def_wr) begin
      elem_sel_r <= ELEM_DEFAULT;
      osr_sel_r <= OSR_DEFAULT;
      repeat_r <= 1'b0;
      bias_en_r <= BIAS_EN_DEFAULT;
      samp_stage2_r <= SAMP_STAGE2_DEFAULT;
      gain13_r <= GAIN13_DEFAULT;
      shift3_r <= SHIFT3_DEFAULT;
      mux_r <= MUX_DEFAULT;
    end else if (wr_acc) begin
      case (paddr)
        ADDR_CONV_CTRL: begin
          elem_sel_r <= pwdata[CC_ELEM_LSB +: 2];
          osr_sel_r <= pwdata[CC_OSR_LSB +: 3];
          repeat_r <= pwdata[CC_REPEAT_BIT];
        end
        ADDR_BIAS_EN: bias_en_r <= pwdata[7:0];
        ADDR_SAMP_STAGE2: samp_stage2_r <= pwdata[7:0];
        ADDR_GAIN13: gain13_r <= pwdata[7:0];
        ADDR_SHIFT3: shift3_r <= pwdata[6:0];
        ADDR_STAT_MUX: mux_r <= pwdata[5:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // sampling clock: rc oscillator model, then selected divider
  logic [7:0] rc_cnt_r;
  logic rc_tick;
  logic [6:0] fs_cnt_r;
  logic [6:0] fs_limit;
  // the rc half period rounds down to whole system cycles
  assign rc_tick = (rc_cnt_r == 8'(RC_HALF_CYCLES * 2 - 1));

  always_comb begin
    case (samp_stage2_r[7:6])
      FS_DIV4: fs_limit = 7'd3;
      FS_DIV8: fs_limit = 7'd7;
      FS_DIV32: fs_limit = 7'd31;
      FS_SLOW: fs_limit = 7'(SLOW_DIV - 1);
      default: fs_limit = 7'd3;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rc_cnt_r <= 8'h00;
    end else if (clk_en) begin
      rc_cnt_r <= rc_tick ? 8'h00 : rc_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      fs_cnt_r <= 7'h00;
      sample_strobe <= 1'b0;
    end else if (clk_en) begin
      sample_strobe <= 1'b0;
      if (rc_tick) begin
        if (fs_cnt_r >= fs_limit) begin
          fs_cnt_r <= 7'h00;
          sample_strobe <= 1'b1;
        end else begin
          fs_cnt_r <= fs_cnt_r + 7'h01;
        end
      end
    end
  end

  // ==========================================================================
  // conversion sequencer
  acc_state_t state_r;
  logic pend_r;
  logic restart_r;
  logic [10:0] osr_cnt_r;
  logic [3:0] elem_cnt_r;
  logic signed [RESULT_W+3:0] acc_r;
  logic [10:0] osr_len;
  logic [3:0] elem_len;
  logic elem_end;
  logic conv_end;
  assign osr_len = 11'(1) << (3 + osr_sel_r);
  assign elem_len = 4'(1) << elem_sel_r;
  assign elem_end = (osr_cnt_r == osr_len - 11'h001);
  assign conv_end = elem_end && (elem_cnt_r == elem_len - 4'h1);

  // a start during a conversion is held until the next idle pass
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pend_r <= 1'b0;
      restart_r <= 1'b0;
    end else if (clk_en) begin
      if (start_wr) begin
        pend_r <= 1'b1;
      end else if (state_r == ACC_IDLE && sample_strobe) begin
        pend_r <= 1'b0;
      end
      if (def_wr) begin
        restart_r <= 1'b1;
      end else if (sample_strobe && state_r != ACC_DONE) begin
        // a restore seen in the done pass must live on until the idle pass starts
        restart_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= ACC_IDLE;
      osr_cnt_r <= 11'h000;
      elem_cnt_r <= 4'h0;
      acc_r <= '0;
      chop_phase <= 1'b0;
    end else if (clk_en && sample_strobe) begin
      case (state_r)
        ACC_IDLE: begin
          // start only on a sampling edge, so busy lags by up to one period
          if (pend_r || repeat_r || restart_r) begin
            state_r <= ACC_RUN;
            osr_cnt_r <= 11'h000;
            elem_cnt_r <= 4'h0;
            acc_r <= '0;
            chop_phase <= 1'b0;
          end
        end
        ACC_RUN: begin
          if (restart_r) begin
            osr_cnt_r <= 11'h000;
            elem_cnt_r <= 4'h0;
            acc_r <= '0;
            chop_phase <= 1'b0;
          end else begin
            // chopped phases subtract, cancelling offset across elementaries
            if (modulator_bit ^ chop_phase) begin
              acc_r <= acc_r + 20'sd1;
            end else begin
              acc_r <= acc_r - 20'sd1;
            end
            if (conv_end) begin
              state_r <= ACC_DONE;
            end else if (elem_end) begin
              osr_cnt_r <= 11'h000;
              elem_cnt_r <= elem_cnt_r + 4'h1;
              chop_phase <= ~chop_phase;
            end else begin
              osr_cnt_r <= osr_cnt_r + 11'h001;
            end
          end
        end
        ACC_DONE: state_r <= ACC_IDLE;
        default: state_r <= ACC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // result and end-of-conversion pulse
  // result only moves at a completion, so byte reads between conversions agree
  logic done_evt;
  assign done_evt = clk_en && sample_strobe && state_r == ACC_RUN && conv_end && !restart_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      result <= '0;
      conversion_done <= 1'b0;
    end else if (clk_en) begin
      conversion_done <= done_evt;
      if (done_evt) begin
        result <= acc_r[RESULT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // analog control outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modulator_on <= 1'b0;
      stage_enable <= 3'h0;
      converter_bias_sel <= 2'h0;
      amplifier_bias_sel <= 2'h0;
      stage_one_gain <= 1'b0;
      stage_two_gain <= 2'h0;
      stage_two_shift <= 4'h0;
      stage_three_gain <= 7'h00;
      stage_three_shift <= 7'h00;
      input_select <= 5'h00;
      reference_select <= 1'b0;
    end else if (clk_en) begin
      modulator_on <= bias_en_r[0];
      stage_enable <= bias_en_r[3:1];
      converter_bias_sel <= bias_en_r[7:6];
      amplifier_bias_sel <= bias_en_r[5:4];
      stage_one_gain <= gain13_r[7];
      stage_two_gain <= samp_stage2_r[5:4];
      stage_two_shift <= samp_stage2_r[3:0];
      stage_three_gain <= gain13_r[6:0];
      stage_three_shift <= shift3_r;
      input_select <= mux_r[5:1];
      reference_select <= mux_r[0];
    end
  end

  // ==========================================================================
  // apb read and handshake
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr)
      ADDR_RESULT_LOW: rd_byte = result[7:0];
      ADDR_RESULT_HIGH: rd_byte = result[15:8];
      // start and test read zero
      ADDR_CONV_CTRL: rd_byte = {1'b0, elem_sel_r, osr_sel_r, repeat_r, 1'b0};
      ADDR_BIAS_EN: rd_byte = bias_en_r;
      ADDR_SAMP_STAGE2: rd_byte = samp_stage2_r;
      ADDR_GAIN13: rd_byte = gain13_r;
      ADDR_SHIFT3: rd_byte = {1'b0, shift3_r};
      ADDR_STAT_MUX: rd_byte = {state_r == ACC_RUN, 1'b0, mux_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      // one wait state: ready answers the cycle after the access is taken
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_acc) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end
endmodule

/* File: include/acc_pkg.sv */
package acc_pkg;
  // ==========================================================================
  // register map (byte addresses, one word each)
  localparam logic [11:0] ADDR_RESULT_LOW = 12'h000;
  localparam logic [11:0] ADDR_RESULT_HIGH = 12'h004;
  localparam logic [11:0] ADDR_CONV_CTRL = 12'h008;
  localparam logic [11:0] ADDR_BIAS_EN = 12'h00C;
  localparam logic [11:0] ADDR_SAMP_STAGE2 = 12'h010;
  localparam logic [11:0] ADDR_GAIN13 = 12'h014;
  localparam logic [11:0] ADDR_SHIFT3 = 12'h018;
  localparam logic [11:0] ADDR_STAT_MUX = 12'h01C;
  // ==========================================================================
  // field positions
  localparam int CC_START_BIT = 7;
  localparam int CC_ELEM_LSB = 5;
  localparam int CC_OSR_LSB = 2;
  localparam int CC_REPEAT_BIT = 1;
  localparam int CC_TEST_BIT = 0;
  localparam int SM_BUSY_BIT = 7;
  localparam int SM_DEF_BIT = 6;
  localparam int SM_INSEL_LSB = 1;
  localparam int SM_REFSEL_BIT = 0;
  // ==========================================================================
  // reset and default values
  localparam logic [1:0] ELEM_DEFAULT = 2'h1;
  localparam logic [2:0] OSR_DEFAULT = 3'h2;
  localparam logic [7:0] BIAS_EN_DEFAULT = 8'hF1;
  localparam logic [7:0] SAMP_STAGE2_DEFAULT = 8'h00;
  localparam logic [7:0] GAIN13_DEFAULT = 8'h00;
  localparam logic [6:0] SHIFT3_DEFAULT = 7'h00;
  localparam logic [5:0] MUX_DEFAULT = 6'h00;
  // ==========================================================================
  // timing: rc oscillator and the fixed ~8 kHz sampling choice
  localparam int RC_FREQ_HZ = 512000;
  localparam int SYS_FREQ_HZ = 20000000;
  localparam int SLOW_FS_HZ = 8000;
  localparam int RC_HALF_CYCLES = SYS_FREQ_HZ / (2 * RC_FREQ_HZ);
  localparam int SLOW_DIV = RC_FREQ_HZ / SLOW_FS_HZ;
  localparam logic [1:0] FS_DIV4 = 2'h0;
  localparam logic [1:0] FS_DIV8 = 2'h1;
  localparam logic [1:0] FS_DIV32 = 2'h2;
  localparam logic [1:0] FS_SLOW = 2'h3;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_RUN = 2'b01,
    ACC_DONE = 2'b10
  } acc_state_t;
endpackage

/* File: sim/acc_control_chk.sv */
`timescale 1ns/1ns
// ==========================================
// port checker
module acc_chk
  import acc_pkg::*;
#(
  parameter int RESULT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stage_one_gain,
  input wire logic [6:0] stage_three_gain,
  input wire logic [4:0] input_select,
  input wire logic reference_select,
  input wire logic sample_strobe,
  input wire logic conversion_done,
  input wire logic [RESULT_W-1:0] result
);
  logic [7:0] wd_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !clk_en);
  always_ff @(posedge clk_sys) begin
    wd_r <= pwdata[7:0];
  end
  sequence acc_taken;
    clk_en && psel && penable && !pready;
  endsequence
  sequence wr_end(a);
    psel && penable && pwrite && pready && paddr == a;
  endsequence
  chk_ready_wait: assert property (acc_taken |=> pready)
    else $error("ready missing after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (
    pready && paddr > ADDR_STAT_MUX |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped access not refused");
  chk_ctrl_zero: assert property (
    pready && !pwrite && paddr == ADDR_CONV_CTRL |-> !prdata[CC_START_BIT] && !prdata[CC_TEST_BIT])
    else $error("start or test bit reads one");
  chk_gain_follow: assert property (
    wr_end(ADDR_GAIN13) |=> {stage_one_gain, stage_three_gain} == wd_r)
    else $error("gain outputs do not follow write");
  chk_mux_follow: assert property (
    wr_end(ADDR_STAT_MUX) ##0 !pwdata[SM_DEF_BIT]
      |=> {input_select, reference_select} == wd_r[5:0])
    else $error("mux outputs do not follow write");
  chk_done_pulse: assert property (conversion_done |=> !conversion_done)
    else $error("done longer than one cycle");
  chk_done_strobe: assert property (conversion_done |-> $past(sample_strobe))
    else $error("done not right after a sample");
  chk_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("samples too close");
  chk_result_hold: assert property ($changed(result) |-> conversion_done)
    else $error("result changed without done");
endmodule
bind acc_control acc_chk #(.RESULT_W(RESULT_W)) u_chk (.clk_sys, .reset, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stage_one_gain, .stage_three_gain,
  .input_select, .reference_select, .sample_strobe, .conversion_done, .result);

/* File: sim/acc_mod_model.sv */
`timescale 1ns/1ns
// ==========================================
// modulator stand-in: one new bit per sample
module acc_mod_model (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sample_strobe,
  input wire logic level_hi,
  output logic modulator_bit
);
  // the bit settles after each sample, so the design always sees the previous decision
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      modulator_bit <= 1'b0;
    end else if (sample_strobe) begin
      modulator_bit <= level_hi;
    end
  end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import acc_pkg::*;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, level_hi, modulator_bit, er;
  logic sample_strobe, conversion_done, chop_phase, modulator_on, reference_select;
  logic stage_one_gain, clk_en, strb_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [2:0] stage_enable;
  logic [1:0] converter_bias_sel, amplifier_bias_sel, stage_two_gain;
  logic [3:0] stage_two_shift;
  logic [6:0] stage_three_gain, stage_three_shift;
  logic [4:0] input_select;
  logic [15:0] result, res_a, res_b;
  logic [34:0] cfg;
  int err_count, n_compared, n_done, n_chop, cyc, w, n0, nc, n_strb, gap, last_rise, s0;
  localparam int SP4 = 8 * RC_HALF_CYCLES;
  int fs_div [4] = '{4, 8, 32, SLOW_DIV};
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h28, 8'hF1, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wr_tab [6] = '{8'h7D, 8'hA5, 8'h1B, 8'h85, 8'hC3, 8'h3F};
  logic [7:0] rb_tab [6] = '{8'h7C, 8'hA5, 8'h1B, 8'h85, 8'h43, 8'h3F};
  assign cfg = {modulator_on, stage_enable, converter_bias_sel, amplifier_bias_sel, stage_one_gain,
    stage_two_gain, stage_two_shift, stage_three_gain, stage_three_shift, input_select,
    reference_select};
  acc_control dut (.clk_sys, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .modulator_bit, .modulator_on, .stage_enable, .converter_bias_sel,
    .amplifier_bias_sel, .stage_one_gain, .stage_two_gain, .stage_two_shift, .stage_three_gain,
    .stage_three_shift, .input_select, .reference_select, .sample_strobe, .chop_phase,
    .conversion_done, .result);
  acc_mod_model u_mod (.clk_sys, .reset, .sample_strobe, .level_hi, .modulator_bit);
  // ==========================================
  // clock, event counters and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    if (conversion_done === 1'b1) n_done++;
    if (sample_strobe === 1'b1 && strb_q !== 1'b1) begin
      n_strb++;
      gap = cyc - last_rise;
      last_rise = cyc;
    end
    strb_q = sample_strobe;
    if (chop_phase === 1'b1) n_chop++;
    cyc++;
    if (cyc > 80000) begin
      err_count++;
      end_sim();
    end
  end
  // ==========================================
  // end, check, bus and wait tasks
  task automatic end_sim();
    if (err_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic wr_en, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    chk(35'(n), 35'd2);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00);
    chk(rd_v, {24'h0, x});
  endtask
  task automatic get_res(output logic [15:0] r);
    apb(ADDR_RESULT_LOW, 1'b0, 8'h00);
    r[7:0] = rd_v[7:0];
    apb(ADDR_RESULT_HIGH, 1'b0, 8'h00);
    r[15:8] = rd_v[7:0];
  endtask
  task automatic wait_done(input int k, input int lim);
    w = 0;
    while (n_done < k && w < lim) begin
      @(negedge clk_sys);
      w++;
    end
  endtask
  // ==========================================
  // test sequence
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    level_hi = 1'b1;
    clk_en = 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(12'(i * 4), rst_tab[i]);
    apb(12'h020, 1'b0, 8'h00);
    chk({er, rd_v}, {1'b1, 32'h0});
    for (int i = 0; i < 6; i++) apb(ADDR_CONV_CTRL + 12'(i * 4), 1'b1, wr_tab[i]);
    for (int i = 0; i < 6; i++) rd(ADDR_CONV_CTRL + 12'(i * 4), rb_tab[i]);
    chk(cfg, {1'b1, 3'h2, 2'h2, 2'h2, 1'b1, 2'h1, 4'hB, 7'h05, 7'h43, 5'h1F, 1'b1});
    for (int k = 3; k >= 0; k--) begin
      apb(ADDR_SAMP_STAGE2, 1'b1, {2'(k), 6'h1B});
      s0 = n_strb;
      while (n_strb < s0 + 2) @(negedge clk_sys);
      chk(35'(gap), 35'(2 * RC_HALF_CYCLES * fs_div[k]));
    end
    n0 = n_done;
    apb(ADDR_CONV_CTRL, 1'b1, 8'h80);
    rd_v = 32'h0;
    for (int i = 0; i < 50 && rd_v[SM_BUSY_BIT] !== 1'b1; i++) apb(ADDR_STAT_MUX, 1'b0, 8'h00);
    chk(rd_v[SM_BUSY_BIT], 1'b1);
    apb(ADDR_CONV_CTRL, 1'b1, 8'h80);
    wait_done(n0 + 2, 6000);
    repeat (3000) @(posedge clk_sys);
    chk(35'(n_done - n0), 35'd2);
    get_res(res_a);
    level_hi <= 1'b0;
    apb(ADDR_CONV_CTRL, 1'b1, 8'h80);
    wait_done(n0 + 3, 3000);
    chk(35'(w >= 8 * SP4 && w <= 9 * SP4 + 4), 35'd1);
    get_res(res_b);
    chk({res_a != 16'h0, res_b}, {1'b1, -res_a});
    nc = n_chop;
    apb(ADDR_CONV_CTRL, 1'b1, 8'h22);
    wait_done(n0 + 6, 12000);
    chk(35'(n_done - n0), 35'd6);
    chk(35'(n_chop > nc), 35'd1);
    repeat (1000) @(posedge clk_sys);
    apb(ADDR_CONV_CTRL, 1'b1, 8'h20);
    wait_done(n0 + 7, 3000);
    repeat (4000) @(posedge clk_sys);
    chk(35'(n_done - n0), 35'd7);
    s0 = n_strb;
    clk_en <= 1'b0;
    repeat (400) @(posedge clk_sys);
    clk_en <= 1'b1;
    chk(35'(n_strb - s0), 35'd0);
    apb(ADDR_CONV_CTRL, 1'b1, 8'h80);
    repeat (500) @(posedge clk_sys);
    apb(ADDR_STAT_MUX, 1'b1, 8'h40);
    for (int i = 0; i < 5; i++) rd(ADDR_CONV_CTRL + 12'(i * 4), rst_tab[i + 2]);
    chk(cfg, {1'b1, 3'h0, 2'h3, 2'h3, 1'b0, 2'h0, 4'h0, 7'h0, 7'h0, 5'h0, 1'b0});
    wait_done(n0 + 8, 12000);
    chk(35'(w >= 64 * SP4 - 40 && w <= 65 * SP4), 35'd1);
    end_sim();
  end
endmodule
